// [hdl/rcs_ctrl.sv]
// control, status and interrupt logic of the calendar clock
module rcs_ctrl (
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_n_in,
    // pins and analog sensors
    input  wire logic       osc_clk_in,
    input  wire logic       clock_out_control_pin_in,
    input  wire logic       supply_below_in,
    input  wire logic       osc_halt_in,
    // time counter events
    input  wire logic       weekly_match_in,
    input  wire logic       daily_match_in,
    input  wire logic       min_roll_in,
    input  wire logic       hour_roll_in,
    input  wire logic       month_roll_in,
    input  wire logic       adjust_tick_in,
    input  wire logic [5:0] hour24_in,
    // register port
    input  wire logic [3:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    output logic      [7:0] reg_rdata_out,
    // outputs
    output logic      [7:0] hour_read_out,
    output logic            irq_out_a_n_out,
    output logic            irq_out_b_n_out,
    output logic            slow_clock_out,
    output logic            second_tick_out,
    output logic            hour_24_mode_out,
    output logic            test_mode_out,
    output logic            supply_threshold_select_out,
    output logic            supply_monitor_on_out,
    output logic      [6:0] freq_adjust_out
);

    // ----------------------------------------
    // decode functions
    // ----------------------------------------
    function automatic logic per_low_f(input logic [2:0] code,
                                       input logic [14:0] div,
                                       input logic lvl);
        unique case (code)
            rcs_pkg::PER_OFF: per_low_f = 1'b0;
            rcs_pkg::PER_LOW: per_low_f = 1'b1;
            rcs_pkg::PER_2HZ: per_low_f = !div[rcs_pkg::DIV_2HZ_BIT];
            rcs_pkg::PER_1HZ: per_low_f = !div[rcs_pkg::DIV_1HZ_BIT];
            default:          per_low_f = lvl;
        endcase
    endfunction

    function automatic logic [7:0] hour_f(input logic [5:0] h, input logic h24);
        logic [4:0] b;
        logic [4:0] p;
        b = 5'(h[5:4]) * 5'h0A + 5'(h[3:0]);
        p = b - 5'h0C;
        if (h24 || (b != 5'h00 && b < 5'h0C)) begin
            hour_f = {2'b00, h};
        end else if (b == 5'h00) begin
            hour_f = 8'h12;
        end else if (b == 5'h0C) begin
            hour_f = 8'h32;
        end else if (p >= 5'h0A) begin
            hour_f = 8'h30 | {4'h0, 4'(p - 5'h0A)};
        end else begin
            hour_f = 8'h20 | {4'h0, 4'(p)};
        end
    endfunction

    // ----------------------------------------
    // synchronised pins
    // ----------------------------------------
    logic [3:0] pin_s;

    rcs_sync #(
        .WIDTH (4)
    ) u_sync (
        .clk_in     (mclk_in),
        .reset_n_in (reset_n_in),
        .async_in   ({osc_clk_in, clock_out_control_pin_in, supply_below_in,
                      osc_halt_in}),
        .sync_out   (pin_s)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    rcs_pkg::rcs_state_t st;
    rcs_pkg::rcs_state_t next_st;
    logic                osc_edge;
    logic                wr_c2;
    logic                lvl_event;
    logic [14:0]         step;
    logic [1:0]          match;

    always_comb begin
        next_st = st;
        osc_edge = pin_s[3] && !st.osc_d;
        wr_c2 = reg_wr_in && reg_addr_in == rcs_pkg::ADDR_CTRL2;
        match = {daily_match_in, weekly_match_in};
        step = '0;
        lvl_event = 1'b0;
        next_st.osc_d = pin_s[3];
        next_st.sec_tick = 1'b0;
        // sub-second divider and delayed seconds increment
        if (osc_edge) begin
            if (st.sec_cnt != 2'h0) begin
                next_st.sec_cnt = st.sec_cnt - 2'h1;
                next_st.sec_tick = st.sec_cnt == 2'h1;
            end
            if (st.div == rcs_pkg::DIV_MAX) begin
                next_st.div = '0;
                next_st.sec_cnt = rcs_pkg::SEC_DLY_OSC;
            end else begin
                next_st.div = st.div + 15'h0001;
            end
        end
        // frequency correction moves the divider within the low half
        if (adjust_tick_in && !st.div[rcs_pkg::DIV_1HZ_BIT] && st.adj[5:1] != 5'h00) begin
            step = {8'h00, st.adj[5:0] - 6'h01, 1'b0};
            if (step > rcs_pkg::CORR_MAX_OSC) begin
                step = rcs_pkg::CORR_MAX_OSC;
            end
            if (!st.adj[6]) begin
                next_st.div = st.div + step;
            end else if (st.div >= step) begin
                next_st.div = st.div - step;
            end
        end
        if (reg_wr_in && reg_addr_in == rcs_pkg::ADDR_SECONDS) begin
            next_st.div = '0;
            next_st.sec_cnt = 2'h0;
        end
        // register writes
        if (reg_wr_in && reg_addr_in == rcs_pkg::ADDR_ADJUST) begin
            next_st.adj = reg_wdata_in[6:0];
        end
        if (reg_wr_in && reg_addr_in == rcs_pkg::ADDR_CTRL1) begin
            next_st.ctrl1 = reg_wdata_in;
        end
        if (wr_c2) begin
            next_st.supply_threshold_select = reg_wdata_in[rcs_pkg::C2_THRESH_SEL];
            next_st.osc_good = reg_wdata_in[rcs_pkg::C2_OSC_GOOD];
            next_st.clkout_disable_a = reg_wdata_in[rcs_pkg::C2_CLKOUT_DISA];
            if (!reg_wdata_in[rcs_pkg::C2_SUPPLY_LOW]) begin
                next_st.supply_low_flag = 1'b0;
            end
            if (!reg_wdata_in[rcs_pkg::C2_POWER_ON]) begin
                next_st.power_on_flag = 1'b0;
            end
            if (!reg_wdata_in[rcs_pkg::C2_PERIODIC] && st.ctrl1[rcs_pkg::C1_SEL_LEVEL]) begin
                next_st.lvl = 1'b0;
            end
            if (!reg_wdata_in[rcs_pkg::C2_WEEKLY_FLAG]) begin
                next_st.afl[0] = 1'b0;
            end
            if (!reg_wdata_in[rcs_pkg::C2_DAILY_FLAG]) begin
                next_st.afl[1] = 1'b0;
            end
        end
        // events, an event wins over a register write
        if (pin_s[1]) begin
            next_st.supply_low_flag = 1'b1;
        end
        if (pin_s[0]) begin
            next_st.osc_good = 1'b0;
        end
        unique case (next_st.ctrl1[1:0])
            2'h0: lvl_event = 1'b1;
            2'h1: lvl_event = min_roll_in;
            2'h2: lvl_event = hour_roll_in;
            2'h3: lvl_event = month_roll_in;
        endcase
        if (next_st.sec_tick && next_st.ctrl1[rcs_pkg::C1_SEL_LEVEL] && lvl_event) begin
            next_st.lvl = 1'b1;
        end
        for (int i = 0; i < 2; i++) begin
            if (match[i] && next_st.ctrl1[rcs_pkg::C1_WEEKLY_EN - i]) begin
                next_st.apend[i] = 1'b1;
                next_st.acnt[i] = 2'h0;
            end else if (st.apend[i] && osc_edge) begin
                if (st.acnt[i] == rcs_pkg::ALARM_DLY_OSC - 2'h1) begin
                    next_st.afl[i] = 1'b1;
                    next_st.apend[i] = 1'b0;
                end else begin
                    next_st.acnt[i] = st.acnt[i] + 2'h1;
                end
            end
            if (!next_st.ctrl1[rcs_pkg::C1_WEEKLY_EN - i]) begin
                next_st.afl[i] = 1'b0;
                next_st.apend[i] = 1'b0;
            end
        end
        // power-on state clears control bits
        if (next_st.power_on_flag) begin
            next_st.ctrl1 = rcs_pkg::CTRL1_RESET;
            next_st.adj = rcs_pkg::ADJUST_RESET;
            next_st.supply_threshold_select = 1'b0;
            next_st.supply_low_flag = 1'b0;
            next_st.clkout_disable_a = 1'b0;
            next_st.lvl = 1'b0;
            next_st.afl = 2'b00;
            next_st.apend = 2'b00;
        end
        // outputs
        next_st.per_low = per_low_f(next_st.ctrl1[2:0], next_st.div, next_st.lvl);
        next_st.irq_a_n = !(next_st.per_low || next_st.afl[1]);
        next_st.irq_b_n = !next_st.afl[0];
        next_st.clk_out = pin_s[3] && pin_s[2] &&
            !(next_st.ctrl1[rcs_pkg::C1_CLKOUT_DISB] && next_st.clkout_disable_a);
        next_st.hour_rd = hour_f(hour24_in, next_st.ctrl1[rcs_pkg::C1_HOUR24]);
        unique case (reg_addr_in)
            rcs_pkg::ADDR_ADJUST: next_st.rdata = {1'b0, st.adj};
            rcs_pkg::ADDR_CTRL1:  next_st.rdata = st.ctrl1;
            rcs_pkg::ADDR_CTRL2:  next_st.rdata = {st.supply_threshold_select,
                                                   st.supply_low_flag, st.osc_good,
                                                   st.power_on_flag, st.clkout_disable_a,
                                                   st.per_low, st.afl[0], st.afl[1]};
            default:              next_st.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st <= rcs_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata_out = st.rdata;
    assign hour_read_out = st.hour_rd;
    assign irq_out_a_n_out = st.irq_a_n;
    assign irq_out_b_n_out = st.irq_b_n;
    assign slow_clock_out = st.clk_out;
    assign second_tick_out = st.sec_tick;
    assign hour_24_mode_out = st.ctrl1[rcs_pkg::C1_HOUR24];
    assign test_mode_out = st.ctrl1[rcs_pkg::C1_TEST];
    assign supply_threshold_select_out = st.supply_threshold_select;
    assign supply_monitor_on_out = !st.supply_low_flag;
    assign freq_adjust_out = st.adj;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);

    sequence startup_kept;
        st.power_on_flag && !(wr_c2 && !reg_wdata_in[rcs_pkg::C2_POWER_ON]);
    endsequence

    sequence alarm_armed;
        weekly_match_in && st.ctrl1[rcs_pkg::C1_WEEKLY_EN] && !st.afl[0] && !st.power_on_flag;
    endsequence

    startup_clear_a: assert property (startup_kept |=> st.ctrl1 == 8'h00 && st.irq_b_n)
        else $error("control not cleared under power-on flag");
    startup_sticky_a: assert property (startup_kept |=> st.power_on_flag)
        else $error("power-on flag lost without a zero write");
    supply_sticky_a: assert property (st.supply_low_flag && !(wr_c2 && !reg_wdata_in[6])
                                      |=> st.supply_low_flag)
        else $error("supply-low flag lost without a zero write");
    osc_halt_a: assert property (pin_s[0] |=> !st.osc_good)
        else $error("oscillation-good not cleared on halt");
    alarm_delay_a: assert property (alarm_armed |=> !st.afl[0] ##1 !st.afl[0])
        else $error("alarm flag set without delay");
    clkout_gate_a: assert property (st.ctrl1[4] && st.clkout_disable_a && !reg_wr_in
                                    |=> !slow_clock_out)
        else $error("slow clock runs with both disables set");
    fixed_low_a: assert property (st.ctrl1[2:0] == 3'h1 && !reg_wr_in && !st.power_on_flag
                                  |=> !irq_out_a_n_out && st.per_low)
        else $error("fixed-low code does not hold interrupt low");
    flag_read_a: assert property (reg_addr_in == rcs_pkg::ADDR_CTRL2 && !st.afl[1]
                                  |=> reg_rdata_out[2] == !$past(irq_out_a_n_out))
        else $error("periodic flag does not follow output");
    sec_write_a: assert property (reg_wr_in && reg_addr_in == 4'h0 && st.ctrl1[2:1] == 2'h1
                                  && !st.power_on_flag |=> st.div == 15'h0000 && !irq_out_a_n_out)
        else $error("seconds write did not reset divider");
    level_release_a: assert property (wr_c2 && !reg_wdata_in[2] && st.ctrl1[2] &&
                                      !next_st.sec_tick && !st.afl[1] |=> irq_out_a_n_out)
        else $error("level interrupt not released by zero write");

endmodule

// [hdl/rcs_pkg.sv]
// constants, register map and state type of the clock control block
package rcs_pkg;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [3:0] ADDR_SECONDS = 4'h0;
    localparam logic [3:0] ADDR_ADJUST  = 4'h7;
    localparam logic [3:0] ADDR_CTRL1   = 4'hE;
    localparam logic [3:0] ADDR_CTRL2   = 4'hF;

    // ----------------------------------------
    // control_one fields
    // ----------------------------------------
    localparam int C1_WEEKLY_EN   = 7;
    localparam int C1_DAILY_EN    = 6;
    localparam int C1_HOUR24      = 5;
    localparam int C1_CLKOUT_DISB = 4;
    localparam int C1_TEST        = 3;
    localparam int C1_SEL_LEVEL   = 2;

    // ----------------------------------------
    // status_control_two fields
    // ----------------------------------------
    localparam int C2_THRESH_SEL  = 7;
    localparam int C2_SUPPLY_LOW  = 6;
    localparam int C2_OSC_GOOD    = 5;
    localparam int C2_POWER_ON    = 4;
    localparam int C2_CLKOUT_DISA = 3;
    localparam int C2_PERIODIC    = 2;
    localparam int C2_WEEKLY_FLAG = 1;
    localparam int C2_DAILY_FLAG  = 0;

    // ----------------------------------------
    // periodic selector codes
    // ----------------------------------------
    localparam logic [2:0] PER_OFF     = 3'h0;
    localparam logic [2:0] PER_LOW     = 3'h1;
    localparam logic [2:0] PER_2HZ     = 3'h2;
    localparam logic [2:0] PER_1HZ     = 3'h3;
    localparam logic [2:0] PER_SECOND  = 3'h4;
    localparam logic [2:0] PER_MINUTE  = 3'h5;
    localparam logic [2:0] PER_HOUR    = 3'h6;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL1_RESET  = 8'h00;
    localparam logic [6:0] ADJUST_RESET = 7'h00;

    // ----------------------------------------
    // divider and timing, in nanoseconds and oscillator cycles
    // ----------------------------------------
    localparam int          DIV_W          = 15;
    localparam logic [14:0] DIV_MAX        = 15'h7FFF;
    localparam int          DIV_2HZ_BIT    = 13;
    localparam int          DIV_1HZ_BIT    = 14;
    localparam int          OSC_PERIOD_NS  = 30518;
    localparam int          SEC_DELAY_NS   = 92000;
    localparam int          ALARM_DELAY_NS = 61000;
    localparam int          CORR_MAX_NS    = 3784000;
    localparam logic [1:0]  SEC_DLY_OSC    = 2'(SEC_DELAY_NS / OSC_PERIOD_NS);
    localparam logic [1:0]  ALARM_DLY_OSC  =
        2'((ALARM_DELAY_NS + OSC_PERIOD_NS - 1) / OSC_PERIOD_NS);
    localparam logic [14:0] CORR_MAX_OSC   = 15'(CORR_MAX_NS / OSC_PERIOD_NS);

    // ----------------------------------------
    // state of the control block
    // ----------------------------------------
    typedef struct packed {
        logic [7:0]       ctrl1;
        logic [6:0]       adj;
        logic             supply_threshold_select;
        logic             supply_low_flag;
        logic             osc_good;
        logic             power_on_flag;
        logic             clkout_disable_a;
        logic             lvl;
        logic             per_low;
        logic [1:0]       afl;
        logic [1:0]       apend;
        logic [1:0][1:0]  acnt;
        logic [14:0]      div;
        logic [1:0]       sec_cnt;
        logic             sec_tick;
        logic             osc_d;
        logic             irq_a_n;
        logic             irq_b_n;
        logic             clk_out;
        logic [7:0]       rdata;
        logic [7:0]       hour_rd;
    } rcs_state_t;

    localparam rcs_state_t STATE_RESET = '{
        power_on_flag: 1'b1,
        irq_a_n:       1'b1,
        irq_b_n:       1'b1,
        default:       '0
    };

endpackage

// [hdl/rcs_sync.sv]
// two-stage synchroniser for inputs from outside the clock domain
module rcs_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             reset_n_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// [verification/rcs_host_model.sv]
// host model that drives the register port of the control block
module rcs_host_model (
    // clock
    input  wire logic       mclk_in,
    // register port
    input  wire logic [7:0] reg_rdata_in,
    output logic      [3:0] reg_addr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_wr_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr_out  = 4'h0;
        reg_wdata_out = 8'h00;
        reg_wr_out    = 1'b0;
    end

    // ----------------------------------------
    // register access
    // ----------------------------------------
    // one-cycle strobe; data inverted once released
    task automatic write_reg(input logic [3:0] addr, input logic [7:0] data);
        @(negedge mclk_in);
        reg_addr_out  = addr;
        reg_wdata_out = data;
        reg_wr_out    = 1'b1;
        @(negedge mclk_in);
        reg_wr_out    = 1'b0;
        reg_wdata_out = ~data;
    endtask

    // read data follows the address one edge later
    task automatic read_reg(input logic [3:0] addr, output logic [7:0] data);
        @(negedge mclk_in);
        reg_addr_out = addr;
        @(negedge mclk_in);
        data = reg_rdata_in;
    endtask
endmodule

// [verification/testbench.sv]
// self-checking bench of the clock control, status and interrupt block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic       mclk = 1'b0;
    logic       reset_n = 1'b0;
    logic       osc_clk = 1'b0;
    logic       clk_pin = 1'b0;
    logic       supply_below = 1'b0;
    logic       osc_halt = 1'b0;
    logic       weekly_match = 1'b0;
    logic       daily_match = 1'b0;
    logic       idle_lvl = 1'b0;
    logic [5:0] hour24 = 6'h00;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic       reg_wr;
    logic [7:0] reg_rdata;
    logic [7:0] hour_read;
    logic       irq_a_n;
    logic       irq_b_n;
    logic       slow_clk;
    logic       sec_tick;
    logic       h24;
    logic       test_mode;
    logic       thresh;
    logic       mon_on;
    logic [6:0] adj;
    int         num_errors = 0;
    int         comparisons = 0;
    logic [5:0] hr_in [7] = '{6'h00, 6'h01, 6'h11, 6'h12, 6'h13, 6'h23, 6'h09};
    logic [7:0] hr_12 [7] = '{8'h12, 8'h01, 8'h11, 8'h32, 8'h21, 8'h31, 8'h09};
    // pin, disable a, disable b, expect running
    logic [3:0] clk_case [5] = '{4'b1001, 4'b1101, 4'b1011, 4'b1110, 4'b0000};

    always #2.5 mclk = ~mclk;
    initial begin
        #1;
        forever #32 osc_clk = ~osc_clk;
    end

    rcs_host_model host_u (
        .mclk_in       (mclk),
        .reg_rdata_in  (reg_rdata),
        .reg_addr_out  (reg_addr),
        .reg_wdata_out (reg_wdata),
        .reg_wr_out    (reg_wr)
    );

    rcs_ctrl dut_u (
        .mclk_in                     (mclk),
        .reset_n_in                  (reset_n),
        .osc_clk_in                  (osc_clk),
        .clock_out_control_pin_in    (clk_pin),
        .supply_below_in             (supply_below),
        .osc_halt_in                 (osc_halt),
        .weekly_match_in             (weekly_match),
        .daily_match_in              (daily_match),
        .min_roll_in                 (idle_lvl),
        .hour_roll_in                (idle_lvl),
        .month_roll_in               (idle_lvl),
        .adjust_tick_in              (idle_lvl),
        .hour24_in                   (hour24),
        .reg_addr_in                 (reg_addr),
        .reg_wdata_in                (reg_wdata),
        .reg_wr_in                   (reg_wr),
        .reg_rdata_out               (reg_rdata),
        .hour_read_out               (hour_read),
        .irq_out_a_n_out             (irq_a_n),
        .irq_out_b_n_out             (irq_b_n),
        .slow_clock_out              (slow_clk),
        .second_tick_out             (sec_tick),
        .hour_24_mode_out            (h24),
        .test_mode_out               (test_mode),
        .supply_threshold_select_out (thresh),
        .supply_monitor_on_out       (mon_on),
        .freq_adjust_out             (adj)
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic give_verdict();
        if (num_errors == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic rd_chk(input string name, input logic [3:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        host_u.read_reg(addr, d);
        check(name, d, exp);
    endtask

    task automatic slow_chk(input logic run);
        int   t;
        logic prev;
        t = 0;
        prev = slow_clk;
        repeat (64) begin
            @(negedge mclk);
            if (slow_clk !== prev) t++;
            prev = slow_clk;
        end
        check("slow clock running", 8'(t > 0), 8'(run));
        if (!run) check("slow clock level", 8'(slow_clk), 8'h00);
    endtask

    task automatic pulse(input logic wk);
        @(negedge mclk);
        weekly_match = wk;
        daily_match  = ~wk;
        @(negedge mclk);
        weekly_match = 1'b0;
        daily_match  = 1'b0;
    endtask

    task automatic wait_irq(input string name, input logic is_a);
        int n;
        n = 0;
        while ((is_a ? irq_a_n : irq_b_n) !== 1'b0 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        check(name, 8'(is_a ? irq_a_n : irq_b_n), 8'h00);
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        cyc(6);
        reset_n = 1'b1;
        cyc(2);
        rd_chk("ctrl2 reset", rcs_pkg::ADDR_CTRL2, 8'h10);
        rd_chk("ctrl1 reset", rcs_pkg::ADDR_CTRL1, 8'h00);
        rd_chk("adjust reset", rcs_pkg::ADDR_ADJUST, 8'h00);
        check("irq a idle", 8'(irq_a_n), 8'h01);
        host_u.write_reg(rcs_pkg::ADDR_CTRL1, 8'hE0);
        rd_chk("ctrl1 locked", rcs_pkg::ADDR_CTRL1, 8'h00);
        host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h00);
        rd_chk("power-on cleared", rcs_pkg::ADDR_CTRL2, 8'h00);
        host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h10);
        rd_chk("power-on write one", rcs_pkg::ADDR_CTRL2, 8'h00);
        host_u.write_reg(rcs_pkg::ADDR_ADJUST, 8'hFF);
        rd_chk("adjust bit7", rcs_pkg::ADDR_ADJUST, 8'h7F);
        check("adjust out", 8'(adj), 8'h7F);
        host_u.write_reg(4'h3, 8'hFF);
        rd_chk("unmapped", 4'h3, 8'h00);
        // hour format first, then time
        host_u.write_reg(rcs_pkg::ADDR_CTRL1, 8'h00);
        host_u.write_reg(rcs_pkg::ADDR_SECONDS, 8'h00);
        for (int i = 0; i < 7; i++) begin
            hour24 = hr_in[i];
            cyc(3);
            check("hour 12h", hour_read, hr_12[i]);
        end
        hour24 = 6'h13;
        host_u.write_reg(rcs_pkg::ADDR_CTRL1, 8'h20);
        cyc(3);
        check("hour mode", 8'(h24), 8'h01);
        check("hour 24h", hour_read, 8'h13);
        for (int i = 0; i < 5; i++) begin
            clk_pin = clk_case[i][3];
            host_u.write_reg(rcs_pkg::ADDR_CTRL2, {4'h0, clk_case[i][2], 3'h0});
            host_u.write_reg(rcs_pkg::ADDR_CTRL1, {3'h0, clk_case[i][1], 4'h0});
            cyc(4);
            slow_chk(clk_case[i][0]);
        end
        host_u.write_reg(rcs_pkg::ADDR_CTRL1, 8'h08);
        cyc(2);
        check("test mode", 8'(test_mode), 8'h01);
        host_u.write_reg(rcs_pkg::ADDR_CTRL1, 8'h00);
        host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h80);
        cyc(2);
        check("threshold", 8'(thresh), 8'h01);
        check("test mode off", 8'(test_mode), 8'h00);
        supply_below = 1'b1;
        host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h00);
        cyc(5);
        rd_chk("supply low set", rcs_pkg::ADDR_CTRL2, 8'h40);
        check("monitor off", 8'(mon_on), 8'h00);
        supply_below = 1'b0;
        host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h40);
        cyc(4);
        rd_chk("supply low sticks", rcs_pkg::ADDR_CTRL2, 8'h40);
        host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h20);
        rd_chk("supply low cleared", rcs_pkg::ADDR_CTRL2, 8'h20);
        check("monitor on", 8'(mon_on), 8'h01);
        osc_halt = 1'b1;
        cyc(5);
        host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h20);
        rd_chk("osc good halted", rcs_pkg::ADDR_CTRL2, 8'h00);
        osc_halt = 1'b0;
        cyc(5);
        rd_chk("osc good stays", rcs_pkg::ADDR_CTRL2, 8'h00);
        for (int c = 0; c < 8; c++) begin
            host_u.write_reg(rcs_pkg::ADDR_CTRL1, {5'h00, 3'(c)});
            host_u.write_reg(rcs_pkg::ADDR_SECONDS, 8'h00);
            if (c > 3) begin
                host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h00);
            end
            cyc(3);
            check("periodic output", 8'(irq_a_n), 8'(c == 0 || c > 3));
            check("second tick", 8'(sec_tick), 8'h00);
            rd_chk("periodic flag", rcs_pkg::ADDR_CTRL2, {5'h00, c > 0 && c < 4, 2'h0});
        end
        host_u.write_reg(rcs_pkg::ADDR_CTRL1, 8'h40);
        pulse(1'b0);
        wait_irq("daily irq", 1'b1);
        rd_chk("daily flag", rcs_pkg::ADDR_CTRL2, 8'h01);
        host_u.write_reg(rcs_pkg::ADDR_CTRL2, 8'h00);
        cyc(2);
        check("daily released", 8'(irq_a_n), 8'h01);
        pulse(1'b1);
        cyc(100);
        check("weekly disabled", 8'(irq_b_n), 8'h01);
        rd_chk("weekly flag off", rcs_pkg::ADDR_CTRL2, 8'h00);
        host_u.write_reg(rcs_pkg::ADDR_CTRL1, 8'hC0);
        pulse(1'b1);
        wait_irq("weekly irq", 1'b0);
        rd_chk("weekly flag", rcs_pkg::ADDR_CTRL2, 8'h02);
        reset_n = 1'b0;
        cyc(6);
        reset_n = 1'b1;
        cyc(2);
        check("irq b after reset", 8'(irq_b_n), 8'h01);
        rd_chk("ctrl1 after reset", rcs_pkg::ADDR_CTRL1, 8'h00);
        rd_chk("ctrl2 after reset", rcs_pkg::ADDR_CTRL2, 8'h10);
        give_verdict();
    end

    initial begin
        #200us;
        num_errors++;
        give_verdict();
    end
endmodule
